// >>> hdl/hswap_pkg.sv
// Package for the hot swap signalling block: register offsets, field positions,
// reset values and ROM constants.
// Assumes a 32-bit APB bus on a single 200 MHz clock.
package hswap_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] HSW_CSR_ADDR = 8'h00; // Hot swap control and status
  localparam logic [7:0] HSW_MISC_ADDR = 8'h04; // Miscellaneous control
  localparam logic [7:0] HSW_IRQ_STS_ADDR = 8'h08; // Interrupt status, clear on read
  localparam logic [7:0] HSW_IRQ_MSK_ADDR = 8'h0C; // Interrupt mask
  localparam logic [7:0] HSW_PRELOAD_ADDR = 8'h10; // Preload status

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int HSW_INS_POS = 7; // Board added flag
  localparam int HSW_EXT_POS = 6; // Removal pending flag
  localparam int HSW_LOO_POS = 3; // Indicator on bit
  localparam int HSW_EIM_POS = 1; // Alert mask bit
  localparam int HSW_HSTS_POS = 8; // Handle state bit in misc register
  localparam int HSW_IRQ_INS_POS = 0; // Insertion event
  localparam int HSW_IRQ_EXT_POS = 1; // Extraction event
  localparam int HSW_IRQ_PRE_POS = 2; // Preload done event
  localparam int HSW_PRE_DONE_POS = 0; // Preload finished
  localparam int HSW_PRE_STOP_POS = 1; // Preload stopped on blank ROM

  // ****************************************************************
  // Reset values and constants
  // ****************************************************************
  localparam logic [2:0] HSW_IRQ_MSK_RST = 3'h0;
  localparam logic [7:0] HSW_ROM_BLANK = 8'hFF; // Blank byte at word address 0
  localparam logic [4:0] HSW_ROM_LAST = 5'h1F; // Last preloaded word address
  localparam logic [31:0] HSW_RD_ZERO = 32'h0000_0000;

endpackage

// >>> hdl/hswap_ctrl.sv
// Hot swap signalling: alert output, removal indicator and handle switch
// flag logic, with an APB register slave and a masked interrupt.
// Assumes the serial ROM engine presents preload bytes on a valid strobe and
// that the handle switch input is already synchronous to clk_sys.
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps

// Functional notes
// - Alert pin is pulled low whenever either flag is set and the alert mask is clear.
// - An asserted alert tells the system of an insertion done or a removal about to happen.
// - The removal indicator follows the indicator on bit of the control register.
// - After reset the indicator stays on until preload finished and the handle is closed.
// - Once preload finished, handle switch transitions set the board added and removal pending flags.
// - The raw handle level is read in the misc register, not in the control register.
// - Preload stops if the byte at word address 0 is all ones.
module hswap_ctrl
  import hswap_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic handle_switch_in,
  input wire logic rom_byte_valid,
  input wire logic [4:0] rom_byte_addr,
  input wire logic [7:0] rom_byte_data,
  output logic rom_stop,
  output logic hotswap_alert_n_out,
  output logic hotswap_alert_n_oe,
  output logic removal_indicator_out,
  output logic irq
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [1:0] {HSW_PRELOAD, HSW_WAIT_CLOSE, HSW_RUN} hswap_phase_e;

  typedef struct packed {
    hswap_phase_e phase;
    logic board_added_flag;
    logic removal_pending_flag;
    logic indicator_on_bit;
    logic alert_mask_bit;
    logic handle_prev;
    logic pre_done;
    logic pre_stop;
    logic [2:0] irq_sts;
    logic [2:0] irq_msk;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rom_stop;
    logic alert_oe;
    logic led;
    logic irq;
  } hswap_state_s;

  hswap_state_s cur;
  hswap_state_s nxt;

  // Decode of the first access edge only; the edge that sees pready high ends it
  function automatic logic hsw_wr(input logic [7:0] a);
    hsw_wr = psel && penable && !cur.pready && pwrite && paddr == a;
  endfunction

  function automatic logic hsw_rd(input logic [7:0] a);
    hsw_rd = psel && penable && !cur.pready && !pwrite && paddr == a;
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic ins_evt;
    logic ext_evt;
    logic pre_evt;
    logic known;
    logic [2:0] evt;
    ins_evt = 1'b0;
    ext_evt = 1'b0;
    pre_evt = 1'b0;
    known = 1'b0;
    evt = 3'h0;
    nxt = cur;
    nxt.pready = 1'b0;
    nxt.pslverr = 1'b0;
    nxt.prdata = HSW_RD_ZERO;
    nxt.handle_prev = handle_switch_in;

    // Preload tracking, blank ROM stops the load
    if (!cur.pre_done && rom_byte_valid) begin
      if (rom_byte_addr == 5'h00 && rom_byte_data == HSW_ROM_BLANK) begin
        nxt.rom_stop = 1'b1;
        nxt.pre_stop = 1'b1;
        nxt.pre_done = 1'b1;
        pre_evt = 1'b1;
      end else if (rom_byte_addr == HSW_ROM_LAST) begin
        nxt.pre_done = 1'b1;
        pre_evt = 1'b1;
      end
    end

    // Handle closing adds the board, opening asks for removal
    if (cur.phase == HSW_RUN && handle_switch_in != cur.handle_prev) begin
      ins_evt = handle_switch_in;
      ext_evt = !handle_switch_in;
    end

    // Indicator hold after reset
    unique case (cur.phase)
      HSW_PRELOAD: begin
        if (cur.pre_done) begin
          nxt.phase = HSW_WAIT_CLOSE;
        end
      end
      HSW_WAIT_CLOSE: begin
        if (handle_switch_in) begin
          nxt.phase = HSW_RUN;
          ins_evt = 1'b1;
        end
      end
      HSW_RUN: begin
      end
    endcase

    // Register writes; flags are write one to clear, set wins
    if (hsw_wr(HSW_CSR_ADDR)) begin
      if (pwdata[HSW_INS_POS]) begin
        nxt.board_added_flag = 1'b0;
      end
      if (pwdata[HSW_EXT_POS]) begin
        nxt.removal_pending_flag = 1'b0;
      end
      nxt.indicator_on_bit = pwdata[HSW_LOO_POS];
      nxt.alert_mask_bit = pwdata[HSW_EIM_POS];
    end
    if (hsw_wr(HSW_IRQ_MSK_ADDR)) begin
      nxt.irq_msk = pwdata[2:0];
    end
    if (ins_evt) begin
      nxt.board_added_flag = 1'b1;
    end
    if (ext_evt) begin
      nxt.removal_pending_flag = 1'b1;
    end

    // Register reads; status clears on read, new events win
    known = paddr == HSW_CSR_ADDR || paddr == HSW_MISC_ADDR || paddr == HSW_IRQ_STS_ADDR
      || paddr == HSW_IRQ_MSK_ADDR || paddr == HSW_PRELOAD_ADDR;
    if (psel && penable && !cur.pready) begin
      nxt.pready = 1'b1;
      nxt.pslverr = !known;
    end
    if (hsw_rd(HSW_CSR_ADDR)) begin
      nxt.prdata[HSW_INS_POS] = cur.board_added_flag;
      nxt.prdata[HSW_EXT_POS] = cur.removal_pending_flag;
      nxt.prdata[HSW_LOO_POS] = cur.indicator_on_bit;
      nxt.prdata[HSW_EIM_POS] = cur.alert_mask_bit;
    end
    if (hsw_rd(HSW_MISC_ADDR)) begin
      nxt.prdata[HSW_HSTS_POS] = handle_switch_in;
    end
    if (hsw_rd(HSW_IRQ_STS_ADDR)) begin
      nxt.prdata[2:0] = cur.irq_sts;
      nxt.irq_sts = 3'h0;
    end
    if (hsw_rd(HSW_IRQ_MSK_ADDR)) begin
      nxt.prdata[2:0] = cur.irq_msk;
    end
    if (hsw_rd(HSW_PRELOAD_ADDR)) begin
      nxt.prdata[HSW_PRE_DONE_POS] = cur.pre_done;
      nxt.prdata[HSW_PRE_STOP_POS] = cur.pre_stop;
    end
    evt[HSW_IRQ_INS_POS] = ins_evt;
    evt[HSW_IRQ_EXT_POS] = ext_evt;
    evt[HSW_IRQ_PRE_POS] = pre_evt;
    nxt.irq_sts = nxt.irq_sts | evt;

    // Pin outputs; the alert pin is open drain, pulled low only
    nxt.alert_oe = (nxt.board_added_flag || nxt.removal_pending_flag)
      && !nxt.alert_mask_bit;
    nxt.led = (nxt.phase != HSW_RUN) || nxt.indicator_on_bit;
    nxt.irq = |(nxt.irq_sts & nxt.irq_msk);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cur <= '0;
      cur.phase <= HSW_PRELOAD;
      cur.irq_msk <= HSW_IRQ_MSK_RST;
      cur.led <= 1'b1;
    end else begin
      cur <= nxt;
    end
  end

  // Outputs straight from flip-flops, except the alert level, which is tied low
  assign prdata = cur.prdata;
  assign pready = cur.pready;
  assign pslverr = cur.pslverr;
  assign rom_stop = cur.rom_stop;
  assign hotswap_alert_n_out = 1'b0;
  assign hotswap_alert_n_oe = cur.alert_oe;
  assign removal_indicator_out = cur.led;
  assign irq = cur.irq;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_flag_up;
    cur.board_added_flag || cur.removal_pending_flag;
  endsequence

  a_alert_drive_low: assert property (@(posedge clk_sys) disable iff (rst)
    (s_flag_up and !cur.alert_mask_bit) |-> hotswap_alert_n_oe)
    else $error("alert not driven with flag set and unmasked");

  a_alert_masked_off: assert property (@(posedge clk_sys) disable iff (rst)
    cur.alert_mask_bit |-> !hotswap_alert_n_oe)
    else $error("alert driven while masked");

  a_alert_never_high: assert property (@(posedge clk_sys) disable iff (rst)
    hotswap_alert_n_oe |-> !hotswap_alert_n_out)
    else $error("alert pin driven high");

  a_led_follows_bit: assert property (@(posedge clk_sys) disable iff (rst)
    (cur.phase == HSW_RUN && cur.indicator_on_bit) |-> removal_indicator_out)
    else $error("indicator off with on bit set");

  a_led_held_on: assert property (@(posedge clk_sys) disable iff (rst)
    (cur.phase != HSW_RUN) |-> removal_indicator_out)
    else $error("indicator released before preload and close");

  a_close_sets_ins: assert property (@(posedge clk_sys) disable iff (rst)
    (cur.phase == HSW_RUN && !cur.handle_prev && handle_switch_in)
    |=> cur.board_added_flag)
    else $error("handle close did not set board added flag");

  a_handle_in_misc: assert property (@(posedge clk_sys) disable iff (rst)
    hsw_rd(HSW_MISC_ADDR) |=> prdata[HSW_HSTS_POS] == $past(handle_switch_in))
    else $error("misc register handle bit wrong");

  a_blank_rom_stop: assert property (@(posedge clk_sys) disable iff (rst)
    (!cur.pre_done && rom_byte_valid && rom_byte_addr == 5'h00
      && rom_byte_data == HSW_ROM_BLANK) |=> rom_stop ##0 cur.pre_done)
    else $error("preload not stopped on blank rom");

  a_irq_level: assert property (@(posedge clk_sys) disable iff (rst)
    irq |-> ##1 (irq || $past(hsw_rd(HSW_IRQ_STS_ADDR)) || $past(hsw_wr(HSW_IRQ_MSK_ADDR))))
    else $error("interrupt dropped without clear");

endmodule

// >>> tb/hswap_far.sv
// Far side model: host pull-up on the alert line, ejector handle and ROM bytes.
// Assumes the bench calls its tasks from one process, all clocked by clk_sys.
`timescale 1ns/1ps
module hswap_far (
  input wire logic clk_sys,
  input wire logic alert_oe,
  input wire logic alert_out,
  output logic alert_wire,
  output logic handle,
  output logic rom_valid,
  output logic [4:0] rom_addr,
  output logic [7:0] rom_data
);
  // Host pull-up, low only while the block pulls
  assign alert_wire = alert_oe ? alert_out : 1'b1;
  // Idle values at time zero
  initial begin
    handle = 1'b0;
    rom_valid = 1'b0;
    rom_addr = 5'h00;
    rom_data = 8'h00;
  end
  // One preload byte, then the bus shows the inverse
  task automatic rom_byte(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    rom_valid <= 1'b1;
    rom_addr <= a;
    rom_data <= d;
    @(posedge clk_sys);
    rom_valid <= 1'b0;
    rom_addr <= ~a;
    rom_data <= ~d;
  endtask
  // Handle moves just after an edge
  task automatic set_handle(input logic v);
    @(posedge clk_sys);
    handle <= v;
  endtask
endmodule

// >>> tb/hswap_ctrl_test.sv
// Testbench for the hot swap block: APB register tests with expected values.
// Assumes the far side model drives the handle switch and preload bytes.
`timescale 1ns/1ps
module hswap_ctrl_test;
  import hswap_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, err, handle, rvalid, rom_stop, a_out, a_oe, a_wire, led, irq;
  logic [4:0] raddr;
  logic [7:0] rdat;
  int error_cnt = 0, n_tests = 0;
  always #2.5 clk_sys = ~clk_sys;
  hswap_ctrl i_hswap_ctrl (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .handle_switch_in(handle), .rom_byte_valid(rvalid),
    .rom_byte_addr(raddr), .rom_byte_data(rdat), .rom_stop(rom_stop),
    .hotswap_alert_n_out(a_out), .hotswap_alert_n_oe(a_oe),
    .removal_indicator_out(led), .irq(irq));
  hswap_far i_hswap_far (.clk_sys(clk_sys), .alert_oe(a_oe), .alert_out(a_out),
    .alert_wire(a_wire), .handle(handle), .rom_valid(rvalid), .rom_addr(raddr),
    .rom_data(rdat));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Verdict and end of run
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Reset for two cycles
  task automatic do_reset;
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
  endtask
  // ****************************************************************
  // Tests
  // ****************************************************************
  // Watchdog
  initial begin
    #50000;
    error_cnt++;
    finish_test();
  end
  // Main sequence
  initial begin
    do_reset();
    repeat (3) @(posedge clk_sys);
    chk(led, 1'b1);
    chk(a_wire, 1'b1);
    apb(1'b0, HSW_IRQ_MSK_ADDR, 32'h0000_0000);
    chk(rd[2:0], HSW_IRQ_MSK_RST);
    i_hswap_far.set_handle(1'b1);
    repeat (4) @(posedge clk_sys);
    chk(led, 1'b1);
    i_hswap_far.set_handle(1'b0);
    i_hswap_far.rom_byte(5'h00, 8'h00);
    i_hswap_far.rom_byte(HSW_ROM_LAST, 8'h00);
    repeat (4) @(posedge clk_sys);
    chk(led, 1'b1);
    $display("Test preload gating done");
    i_hswap_far.set_handle(1'b1);
    repeat (4) @(posedge clk_sys);
    chk(led, 1'b0);
    chk({a_wire, a_oe, a_out}, 3'b010);
    apb(1'b0, HSW_CSR_ADDR, 32'h0000_0000);
    chk(rd[HSW_INS_POS], 1'b1);
    chk(rd[HSW_HSTS_POS], 1'b0);
    apb(1'b0, HSW_MISC_ADDR, 32'h0000_0000);
    chk(rd[HSW_HSTS_POS], 1'b1);
    apb(1'b1, HSW_CSR_ADDR, 32'h0000_0002);
    repeat (2) @(posedge clk_sys);
    chk(a_wire, 1'b1);
    apb(1'b1, HSW_CSR_ADDR, 32'h0000_0008);
    repeat (2) @(posedge clk_sys);
    chk({led, a_wire}, 2'b10);
    apb(1'b1, HSW_CSR_ADDR, 32'h0000_0080);
    repeat (2) @(posedge clk_sys);
    chk({led, a_wire}, 2'b01);
    $display("Test insertion done");
    i_hswap_far.set_handle(1'b0);
    repeat (4) @(posedge clk_sys);
    chk(a_wire, 1'b0);
    apb(1'b0, HSW_CSR_ADDR, 32'h0000_0000);
    chk({rd[HSW_INS_POS], rd[HSW_EXT_POS]}, 2'b01);
    apb(1'b0, HSW_MISC_ADDR, 32'h0000_0000);
    chk(rd[HSW_HSTS_POS], 1'b0);
    apb(1'b1, HSW_IRQ_MSK_ADDR, 32'h0000_0007);
    repeat (2) @(posedge clk_sys);
    chk(irq, 1'b1);
    apb(1'b0, HSW_IRQ_STS_ADDR, 32'h0000_0000);
    chk(rd[HSW_IRQ_EXT_POS], 1'b1);
    repeat (2) @(posedge clk_sys);
    chk(irq, 1'b0);
    i_hswap_far.set_handle(1'b1);
    repeat (4) @(posedge clk_sys);
    apb(1'b0, HSW_CSR_ADDR, 32'h0000_0000);
    chk(rd[HSW_INS_POS], 1'b1);
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk(err, 1'b1);
    chk(rd, HSW_RD_ZERO);
    $display("Test removal done");
    do_reset();
    i_hswap_far.rom_byte(5'h00, HSW_ROM_BLANK);
    repeat (3) @(posedge clk_sys);
    chk(rom_stop, 1'b1);
    apb(1'b0, HSW_PRELOAD_ADDR, 32'h0000_0000);
    chk(rd[1:0], 2'b11);
    $display("Test blank preload done");
    finish_test();
  end
endmodule
